/* core/ctpmc_host.sv */
// Host-side mode controller for a fault-tolerant CAN transceiver
//
// Operation
// - Pin encoding of the four modes
// - Remote node sends long dominant phase
// - Host reads wake, then selects normal
// - Host holds goto-sleep for hold time
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps

module ctpmc_host #(
    parameter int SLEEP_HOLD_DEFAULT = ctpmc_pkg::SLEEP_HOLD_CYCLES
) (
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // APB slave port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transceiver mode pins
    output logic lowPowerSelectN,
    output logic enableOut,
    // Transceiver indications
    input wire logic faultFlagN,
    input wire logic rxdIn,
    input wire logic regulatorOnIn,
    input wire logic logicSupplyOk,
    // Wake indication for the system
    output logic wakeSeenOut
);
    import ctpmc_pkg::*;

    // ==========================================================
    // Input synchronisation
    logic [3:0] syncPins;
    logic faultN;
    logic rxd;
    logic regOn;
    logic supplyOk;

    // Flag pins, regulator sense and supply status enter here
    ctpmc_sync #(
        .WIDTH(4)
    ) uSync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .asyncIn({logicSupplyOk, regulatorOnIn, rxdIn, faultFlagN}),
        .syncOut(syncPins)
    );

    assign faultN = syncPins[0];
    assign rxd = syncPins[1];
    assign regOn = syncPins[2];
    assign supplyOk = syncPins[3];

    // ==========================================================
    // Register and state declarations
    ctpmc_state_t state;
    logic [1:0] curMode;
    logic [1:0] targetMode;
    logic [1:0] pendMode;
    logic autoWake;
    logic [CNT_W-1:0] holdCycles;
    logic [CNT_W-1:0] count;
    logic wakeSeen;
    logic powerOnFlag;
    logic busFault;
    logic cmdPending;
    logic busy;
    logic freshSteady;

    // Bus decode
    logic setupRd;
    logic accWr;
    logic mapped;
    logic wrCtrl;
    logic wrStatus;
    logic wrHold;

    // Wake and fault detection
    logic wakeIndicated;
    logic wakeEvent;
    logic autoCmd;
    logic steadyLow;

    // ==========================================================
    // APB decode; answer in the first access cycle
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_HOLD);
    assign setupRd = psel && !penable && !pwrite;
    assign accWr = psel && penable && pwrite && mapped;
    assign wrCtrl = accWr && (paddr == ADDR_CTRL);
    assign wrStatus = accWr && (paddr == ADDR_STATUS);
    assign wrHold = accWr && (paddr == ADDR_HOLD);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign busy = (state != ST_STEADY) || cmdPending || freshSteady;
    assign wakeSeenOut = wakeSeen;

    // Read data captured in the setup cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (ce && setupRd) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                ADDR_CTRL: begin
                    prdata[CTRL_MODE_LSB +: 2] <= targetMode;
                    prdata[CTRL_AUTO_BIT] <= autoWake;
                end
                ADDR_STATUS: begin
                    prdata[ST_MODE_LSB +: 2] <= curMode;
                    prdata[ST_BUSY_BIT] <= busy;
                    prdata[ST_WAKE_BIT] <= wakeSeen;
                    prdata[ST_PWRON_BIT] <= powerOnFlag;
                    prdata[ST_FAULT_BIT] <= busFault;
                    prdata[ST_REG_BIT] <= regOn;
                    prdata[ST_SUPPLY_BIT] <= supplyOk;
                end
                ADDR_HOLD: begin
                    prdata[CNT_W-1:0] <= holdCycles;
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Control and hold registers
    always_ff @(posedge clk) begin
        if (reset) begin
            targetMode <= MODE_NORMAL;
            autoWake <= 1'b0;
            holdCycles <= CNT_W'(SLEEP_HOLD_DEFAULT);
        end else if (ce) begin
            if (wrCtrl) begin
                targetMode <= pwdata[CTRL_MODE_LSB +: 2];
                autoWake <= pwdata[CTRL_AUTO_BIT];
            end
            if (wrHold) begin
                holdCycles <= pwdata[CNT_W-1:0];
            end
        end
    end

    // ==========================================================
    // Wake detection in the low-power modes
    // Sleep and standby signal wake low on both flag pins; power-on
    // standby only on the receive pin, its fault pin carries the flag
    assign steadyLow = (state == ST_STEADY) && (curMode != MODE_NORMAL) && supplyOk;
    always_comb begin
        wakeIndicated = 1'b0;
        if (curMode == MODE_PWRON_STBY) begin
            wakeIndicated = !rxd;
        end else begin
            wakeIndicated = !rxd || !faultN;
        end
    end
    // A regulator sense that returns high in sleep also marks a wake
    assign wakeEvent = steadyLow &&
        (wakeIndicated || ((curMode == MODE_SLEEP) && regOn));
    assign autoCmd = wakeEvent && autoWake;

    // Sticky wake flag, write one to clear; a new wake wins
    always_ff @(posedge clk) begin
        if (reset) begin
            wakeSeen <= 1'b0;
        end else if (ce) begin
            if (wakeEvent) begin
                wakeSeen <= 1'b1;
            end else if (wrStatus && pwdata[ST_WAKE_BIT]) begin
                wakeSeen <= 1'b0;
            end
        end
    end

    // Power-on flag read out in power-on standby, gone after normal
    always_ff @(posedge clk) begin
        if (reset) begin
            powerOnFlag <= 1'b0;
        end else if (ce) begin
            if (steadyLow && (curMode == MODE_PWRON_STBY)) begin
                powerOnFlag <= !faultN;
            end else if ((state == ST_STEADY) && (curMode == MODE_NORMAL)) begin
                powerOnFlag <= 1'b0;
            end
        end
    end

    // Wiring failure level, valid only in normal mode
    always_ff @(posedge clk) begin
        if (reset) begin
            busFault <= 1'b0;
        end else if (ce) begin
            if ((state == ST_STEADY) && (curMode == MODE_NORMAL) && supplyOk) begin
                busFault <= !faultN;
            end else begin
                busFault <= 1'b0;
            end
        end
    end

    // Busy covers the first steady cycle, while the flags catch up
    always_ff @(posedge clk) begin
        if (reset) begin
            freshSteady <= 1'b1;
        end else if (ce) begin
            freshSteady <= (state != ST_STEADY);
        end
    end

    // ==========================================================
    // Command latch: software write or automatic return to normal
    always_ff @(posedge clk) begin
        if (reset) begin
            cmdPending <= 1'b0;
            pendMode <= MODE_NORMAL;
        end else if (ce) begin
            if (wrCtrl) begin
                cmdPending <= 1'b1;
                pendMode <= pwdata[CTRL_MODE_LSB +: 2];
            end else if (autoCmd && !cmdPending) begin
                cmdPending <= 1'b1;
                pendMode <= MODE_NORMAL;
            end else if (state == ST_STEADY && cmdPending && supplyOk) begin
                cmdPending <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Mode sequencer driving the two mode pins
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_SETTLE;
            curMode <= MODE_NORMAL;
            count <= CNT_W'(SETTLE_CYCLES);
            lowPowerSelectN <= 1'b1;
            enableOut <= 1'b1;
        end else if (ce) begin
            unique case (state)
                ST_STEADY: begin
                    if (cmdPending && !supplyOk) begin
                        state <= ST_WAIT_SUPPLY;
                    end else if (cmdPending) begin
                        unique case (pendMode)
                            MODE_NORMAL: begin
                                lowPowerSelectN <= 1'b1;
                                enableOut <= 1'b1;
                                count <= CNT_W'(SETTLE_CYCLES);
                                state <= ST_SETTLE;
                            end
                            MODE_SLEEP: begin
                                lowPowerSelectN <= 1'b0;
                                enableOut <= 1'b1;
                                count <= holdCycles;
                                state <= ST_HOLD_SLEEP;
                            end
                            MODE_STANDBY: begin
                                lowPowerSelectN <= 1'b0;
                                enableOut <= 1'b0;
                                count <= CNT_W'(SETTLE_CYCLES);
                                state <= ST_SETTLE;
                            end
                            MODE_PWRON_STBY: begin
                                lowPowerSelectN <= 1'b1;
                                enableOut <= 1'b0;
                                count <= CNT_W'(SETTLE_CYCLES);
                                state <= ST_SETTLE;
                            end
                        endcase
                        curMode <= pendMode;
                    end
                end
                ST_WAIT_SUPPLY: begin
                    if (supplyOk) begin
                        state <= ST_STEADY;
                    end
                end
                ST_HOLD_SLEEP: begin
                    // Goto-sleep stays stable for the hold time
                    if (count == CNT_W'(0)) begin
                        lowPowerSelectN <= 1'b0;
                        enableOut <= 1'b0;
                        count <= CNT_W'(SETTLE_CYCLES);
                        state <= ST_SETTLE;
                    end else begin
                        count <= count - CNT_W'(1);
                    end
                end
                ST_SETTLE: begin
                    // Flags are ignored until the device has settled
                    if (count == CNT_W'(0)) begin
                        state <= ST_STEADY;
                    end else begin
                        count <= count - CNT_W'(1);
                    end
                end
            endcase
        end
    end

endmodule

/* core/ctpmc_pkg.sv */
// Constants shared by the transceiver mode controller
package ctpmc_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    // Wait after a pin change before the flag pins are trusted
    localparam int SETTLE_NS = 10000;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least goto-sleep hold time, default for the hold register
    localparam int SLEEP_HOLD_NS = 50000;
    localparam int SLEEP_HOLD_CYCLES = (SLEEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // ==========================================================
    // Register map, byte addresses of aligned words
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_HOLD = 8'h08;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_AUTO_BIT = 2;
    // Status register fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_WAKE_BIT = 3;
    localparam int ST_PWRON_BIT = 4;
    localparam int ST_FAULT_BIT = 5;
    localparam int ST_REG_BIT = 6;
    localparam int ST_SUPPLY_BIT = 7;

    // ==========================================================
    // Mode codes as software writes and reads them
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;
    localparam logic [1:0] MODE_PWRON_STBY = 2'h3;

    // Controller states
    typedef enum logic [1:0] {
        ST_STEADY,
        ST_WAIT_SUPPLY,
        ST_HOLD_SLEEP,
        ST_SETTLE
    } ctpmc_state_t;

endpackage

/* core/ctpmc_sync.sv */
// Two-stage input synchroniser for the transceiver status pins
`timescale 1ns/1ps

module ctpmc_sync #(
    parameter int WIDTH = 4
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    // ==========================================================
    // Per-bit flip-flop pairs; stage one feeds stage two only
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gBit
            logic stageOne;
            always_ff @(posedge clk) begin
                if (reset) begin
                    stageOne <= 1'b1;
                    syncOut[i] <= 1'b1;
                end else if (ce) begin
                    stageOne <= asyncIn[i];
                    syncOut[i] <= stageOne;
                end
            end
        end
    endgenerate

endmodule

/* verif/ctpmc_sva.sv */
// Port assertions for the host mode controller
`timescale 1ns/1ps
module ctpmc_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Watched ports
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic lowPowerSelectN,
    input wire logic enableOut,
    input wire logic logicSupplyOk,
    input wire logic wakeSeenOut
);
    import ctpmc_pkg::*;
    // ====================================
    // Helpers
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic acc = psel && penable;
    wire logic mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_HOLD};
    // ====================================
    // Assertions
    ready_always_a: assert property (acc |-> pready)
        else $error("pready low in access");
    slverr_map_a: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    bad_read_a: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    reset_pins_a: assert property ($fell(reset) |-> lowPowerSelectN && enableOut && !wakeSeenOut)
        else $error("pins or wake wrong after reset");
    freeze_a: assert property (!ce |=> $stable({lowPowerSelectN, enableOut, wakeSeenOut}))
        else $error("state moved with clock enable low");
    sleep_hold_a: assert property ($fell(enableOut) && !lowPowerSelectN && $past(!lowPowerSelectN)
        |-> $past(!lowPowerSelectN && enableOut, 8))
        else $error("goto-sleep held too briefly");
    wake_mode_a: assert property ($rose(wakeSeenOut) |-> !(lowPowerSelectN && enableOut))
        else $error("wake seen in normal mode");
    supply_gate_a: assert property ((!logicSupplyOk)[*6] ##0 (lowPowerSelectN && enableOut)
        |=> lowPowerSelectN && enableOut)
        else $error("pins changed without supply");
    // Main scenarios reached
    cover property ($fell(enableOut) && !lowPowerSelectN);
    cover property ($rose(wakeSeenOut));
    cover property (acc && pslverr);
endmodule

/* verif/ctpmc_xcvr_model.sv */
// Behavioural transceiver mode and wake logic facing the host
`timescale 1ns/1ps
module ctpmc_xcvr_model #(
    parameter int HOLD = 8
) (
    // Clock
    input wire logic clk,
    // Mode pins and supplies
    input wire logic lowPowerSelectN,
    input wire logic enableOut,
    input wire logic logicSupplyOk,
    input wire logic batOn,
    // Events commanded by the bench
    input wire logic wakeEvt,
    input wire logic busFault,
    // Indications
    output logic faultFlagN,
    output logic rxdIn,
    output logic regulatorOnIn,
    // Low termination supply, high while switched to battery
    output logic lowTermBat
);
    logic [1:0] mode = 2'b11;
    logic wakePend = 1'b0;
    logic pwrFlag = 1'b0;
    logic regOn = 1'b0;
    int holdCnt = 0;
    // Internal pin view, forced low without supply
    wire logic [1:0] next_mode = logicSupplyOk ? {lowPowerSelectN, enableOut} : 2'b00;
    // Mode, wake, power-on flag and regulator state
    always_ff @(posedge clk) begin
        mode <= next_mode;
        holdCnt <= (next_mode == 2'b01) ? holdCnt + 1 : 0;
        if (next_mode == 2'b00 && mode == 2'b01 && holdCnt >= HOLD) begin
            regOn <= 1'b0;
        end
        if (next_mode == 2'b11 && mode != 2'b11) begin
            wakePend <= 1'b0;
            pwrFlag <= 1'b0;
        end
        if (wakeEvt && next_mode != 2'b11) begin
            wakePend <= 1'b1;
            regOn <= 1'b1;
        end
        if (next_mode[1] && !mode[1]) begin
            regOn <= 1'b1;
        end
        if (batOn) begin
            pwrFlag <= 1'b1;
            regOn <= 1'b1;
        end
    end
    // Flag lines by mode; pulled high without supply
    assign faultFlagN = !logicSupplyOk || (mode == 2'b11 ? !busFault :
        mode == 2'b10 ? !pwrFlag : !wakePend);
    assign rxdIn = !logicSupplyOk || mode == 2'b11 || !wakePend;
    assign regulatorOnIn = regOn;
    // Termination goes to battery in every low-power mode
    assign lowTermBat = (mode != 2'b11);
endmodule

/* verif/tb_ctpmc_host.sv */
// Self-checking bench for the host mode controller
`timescale 1ns/1ps
module tb_ctpmc_host;
    import ctpmc_pkg::*;
    // ====================================
    // Signals
    logic clk = 0, reset = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic logicSupplyOk = 1, batOn = 1, wakeEvt = 0, busFault = 0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, lowPowerSelectN, enableOut, wakeSeenOut;
    wire logic faultFlagN, rxdIn, regulatorOnIn, lowTermBat;
    int failCount = 0, checked = 0;
    // Rows: mode written, pins expected, status expected
    logic [15:0] rows [5] = '{16'h32D3, 16'h03C0, 16'h20C2, 16'h1081, 16'h03C0};
    // ====================================
    // Design, far side and clock
    ctpmc_host #(.SLEEP_HOLD_DEFAULT(20)) i_ctpmc_host (.clk, .reset, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lowPowerSelectN, .enableOut,
        .faultFlagN, .rxdIn, .regulatorOnIn, .logicSupplyOk, .wakeSeenOut);
    ctpmc_xcvr_model i_ctpmc_xcvr_model (.clk, .lowPowerSelectN, .enableOut, .logicSupplyOk,
        .batOn, .wakeEvt, .busFault, .faultFlagN, .rxdIn, .regulatorOnIn, .lowTermBat);
    initial forever #5 clk = ~clk;
    // ====================================
    // Tasks
    task automatic giveVerdict();
        $display("Comparisons %0d, mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic stall();
        failCount++;
        giveVerdict();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (k >= 50) stall();
    endtask
    task automatic waitIdle();
        int k;
        k = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            k++;
        end while (rd[ST_BUSY_BIT] !== 1'b0 && k < 1500);
        if (k >= 1500) stall();
    endtask
    task automatic wakeUp();
        int k;
        wakeEvt <= 1'b1;
        @(posedge clk);
        wakeEvt <= 1'b0;
        k = 0;
        while (wakeSeenOut !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        if (k >= 200) stall();
    endtask
    // ====================================
    // Main sequence and watchdog
    initial begin
        repeat (60000) @(posedge clk);
        stall();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        batOn <= 1'b0;
        @(posedge clk);
        foreach (rows[k]) begin
            apb(1'b1, ADDR_CTRL, 32'(rows[k][15:12]));
            waitIdle();
            chk("pins", 32'(rows[k][9:8]), 32'({lowPowerSelectN, enableOut}));
            chk("status", 32'(rows[k][7:0]), rd);
            chk("term", 32'(rows[k][9:8] != 2'b11), 32'(lowTermBat));
        end
        busFault <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("busFault", 32'h0000_00E0, rd);
        busFault <= 1'b0;
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk("slverr", 32'h0000_0001, 32'(err));
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        apb(1'b0, ADDR_HOLD, 32'h0000_0000);
        chk("hold", 32'h0000_0014, rd);
        apb(1'b1, ADDR_HOLD, 32'h0000_0010);
        apb(1'b1, ADDR_CTRL, 32'(MODE_SLEEP));
        waitIdle();
        wakeUp();
        apb(1'b1, ADDR_STATUS, 32'h0000_0008);
        chk("wakeHeld", 32'h0000_0001, 32'(wakeSeenOut));
        apb(1'b1, ADDR_CTRL, 32'(MODE_NORMAL));
        waitIdle();
        apb(1'b1, ADDR_STATUS, 32'h0000_0008);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("cleared", 32'h0000_00C0, rd);
        apb(1'b1, ADDR_CTRL, 32'h0000_0006);
        waitIdle();
        wakeUp();
        repeat (4) @(posedge clk);
        waitIdle();
        chk("autoWake", 32'h0000_00C8, rd);
        apb(1'b1, ADDR_STATUS, 32'h0000_0008);
        logicSupplyOk <= 1'b0;
        repeat (5) @(posedge clk);
        apb(1'b1, ADDR_CTRL, 32'(MODE_STANDBY));
        repeat (50) @(posedge clk);
        chk("noSupply", 32'h0000_0006, 32'({lowPowerSelectN, enableOut, wakeSeenOut}));
        logicSupplyOk <= 1'b1;
        waitIdle();
        chk("standby", 32'h0000_00C2, rd);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("rstPins", 32'h0000_0006, 32'({lowPowerSelectN, enableOut, wakeSeenOut}));
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("rstBusy", 32'h0000_0001, 32'(rd[ST_BUSY_BIT]));
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        waitIdle();
        giveVerdict();
    end
endmodule
bind ctpmc_host ctpmc_sva i_ctpmc_sva (.clk, .reset, .ce, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .lowPowerSelectN, .enableOut, .logicSupplyOk, .wakeSeenOut);
